// File: light_result_config_regs.vh
// Register map, field layout and timing constants of the light sensor block
`ifndef LIGHT_RESULT_CONFIG_REGS_VH
`define LIGHT_RESULT_CONFIG_REGS_VH

// ****************************************************************
// Register pointers
// ****************************************************************
`define LRC_ADDR_RESULT 8'h00
`define LRC_ADDR_CONFIG 8'h01

// ****************************************************************
// Reset values
// ****************************************************************
`define LRC_CONFIG_RESET 16'hc810
`define LRC_RESULT_RESET 16'h0000

// ****************************************************************
// Field positions
// ****************************************************************
`define LRC_EXP_HI 15
`define LRC_EXP_LO 12
`define LRC_MAN_HI 11
`define LRC_MAN_LO 0
`define LRC_RANGE_HI 15
`define LRC_RANGE_LO 12
`define LRC_INT_TIME_BIT 11
`define LRC_MODE_HI 10
`define LRC_MODE_LO 9
`define LRC_OVERFLOW_BIT 8
`define LRC_READY_BIT 7
`define LRC_HIGH_BIT 6
`define LRC_LOW_BIT 5
`define LRC_LOWCFG_HI 4
`define LRC_LOWCFG_LO 0
`define LRC_MASK_BIT 2

// ****************************************************************
// Field encodings
// ****************************************************************
`define LRC_RANGE_AUTO 4'hc
`define LRC_RANGE_MAX 4'hb
`define LRC_RANGE_MIN 4'h0
`define LRC_MODE_SHUTDOWN 2'h0
`define LRC_MODE_SINGLE 2'h1

// ****************************************************************
// Timing
// ****************************************************************
`define LRC_CLK_HZ 50000000
`define LRC_MS_PER_S 1000
`define LRC_CLK_PER_MS (`LRC_CLK_HZ / `LRC_MS_PER_S)
`define LRC_SHORT_MS 100
`define LRC_LONG_MS 800

`endif

// File: integration_timer.v
// Integration timer: millisecond divider and integration length counter
`timescale 1ns/1ps
`include "light_result_config_regs.vh"

module integration_timer #(
	parameter CLK_PER_MS = `LRC_CLK_PER_MS,
	parameter DIV_W = 16,
	parameter MS_W = 10
) (
	// Clock and reset
	input wire clk_sys,
	input wire rst,
	// Control
	input wire start,
	input wire abort,
	input wire long_sel,
	// Status
	output wire busy,
	output reg done
);

	// ****************************************************************
	// Counters
	// ****************************************************************
	// Integration lengths in milliseconds, cut to the counter width
	localparam integer SHORT_MS = `LRC_SHORT_MS;
	localparam integer LONG_MS = `LRC_LONG_MS;
	localparam [MS_W-1:0] SHORT_LIM = SHORT_MS[MS_W-1:0];
	localparam [MS_W-1:0] LONG_LIM = LONG_MS[MS_W-1:0];

	reg [DIV_W-1:0] div_q;
	reg [MS_W-1:0] ms_q;
	reg [MS_W-1:0] limit_q;
	reg busy_q;
	wire ms_tick;

	assign busy = busy_q;
	assign ms_tick = (div_q == CLK_PER_MS[DIV_W-1:0] - 1'b1);

	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			div_q <= {DIV_W{1'b0}};
			ms_q <= {MS_W{1'b0}};
			limit_q <= {MS_W{1'b0}};
			busy_q <= 1'b0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start) begin
				// Start wins over abort: a restart clears the count
				div_q <= {DIV_W{1'b0}};
				ms_q <= {MS_W{1'b0}};
				busy_q <= 1'b1;
				limit_q <= long_sel ? LONG_LIM : SHORT_LIM;
			end else if (abort) begin
				busy_q <= 1'b0;
			end else if (busy_q) begin
				if (ms_tick) begin
					div_q <= {DIV_W{1'b0}};
					if (ms_q == limit_q - 1'b1) begin
						busy_q <= 1'b0;
						done <= 1'b1;
					end else begin
						ms_q <= ms_q + 1'b1;
					end
				end else begin
					div_q <= div_q + 1'b1;
				end
			end
		end
	end

endmodule

// File: light_result_config_regs.v
// Result and configuration registers with conversion sequencing
`timescale 1ns/1ps
`include "light_result_config_regs.vh"

module light_result_config_regs #(
	parameter CLK_PER_MS = `LRC_CLK_PER_MS
) (
	// Clock and reset
	input wire clk_sys,
	input wire rst,
	// Register access by pointer
	input wire [7:0] reg_addr,
	input wire reg_wr,
	input wire reg_rd,
	input wire [15:0] reg_wdata,
	output reg [15:0] reg_rdata,
	// Analog front end
	input wire [11:0] afe_mantissa,
	input wire afe_overflow,
	output wire [3:0] afe_range,
	output wire afe_integrating,
	// Limit compare flags from the comparator block
	input wire high_flag_in,
	input wire low_flag_in
);

	// ****************************************************************
	// States and helpers
	// ****************************************************************
	localparam ST_IDLE = 2'b01;
	localparam ST_CONV = 2'b10;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam [15:0] CFG_RST = `LRC_CONFIG_RESET;
	localparam [3:0] RANGE_RST = CFG_RST[`LRC_RANGE_HI:`LRC_RANGE_LO];
	localparam [0:0] TIME_RST = CFG_RST[`LRC_INT_TIME_BIT];
	localparam [1:0] MODE_RST = CFG_RST[`LRC_MODE_HI:`LRC_MODE_LO];
	localparam [4:0] LOWCFG_RST = CFG_RST[`LRC_LOWCFG_HI:`LRC_LOWCFG_LO];

	// First range of a conversion: lowest in auto, clamped when manual
	function [3:0] start_range;
		input [3:0] sel;
		begin
			if (sel == `LRC_RANGE_AUTO)
				start_range = `LRC_RANGE_MIN;
			else if (sel > `LRC_RANGE_MAX)
				start_range = `LRC_RANGE_MAX;
			else
				start_range = sel;
		end
	endfunction

	// Exponent as reported, zeroed by the mask for range codes below the auto code
	function [3:0] shown_exp;
		input [3:0] exp_val;
		input [3:0] sel;
		input mask;
		begin
			if (mask && sel < `LRC_RANGE_AUTO)
				shown_exp = 4'h0;
			else
				shown_exp = exp_val;
		end
	endfunction

	// Conversion mode field of a configuration word
	function [1:0] mode_field;
		input [15:0] word;
		begin
			mode_field = word[`LRC_MODE_HI:`LRC_MODE_LO];
		end
	endfunction

	// ****************************************************************
	// Registers
	// ****************************************************************
	reg [1:0] state_q;
	reg [3:0] range_select_q;
	reg integration_time_select_q;
	reg [1:0] mode_q;
	reg overflow_flag_q;
	reg conversion_ready_flag_q;
	reg [4:0] cfg_low_q;
	reg [3:0] result_exp_q;
	reg [11:0] result_man_q;
	reg [3:0] cur_range_q;
	reg start_pend_q;
	reg overload_seen_q;

	wire cfg_wr;
	wire cfg_rd;
	wire conv_active;
	wire auto_mode;
	wire step_up;
	wire launch;
	wire timer_done;
	wire timer_busy;
	wire finish;
	wire cont_restart;
	wire single_done;
	wire timer_start;
	wire exponent_mask_enable;
	wire [15:0] config_word;
	wire [15:0] result_word;

	assign cfg_wr = reg_wr && (reg_addr == `LRC_ADDR_CONFIG);
	assign cfg_rd = reg_rd && (reg_addr == `LRC_ADDR_CONFIG);
	assign conv_active = (state_q == ST_CONV);
	assign auto_mode = (range_select_q == `LRC_RANGE_AUTO);
	assign exponent_mask_enable = cfg_low_q[`LRC_MASK_BIT];

	// ****************************************************************
	// Conversion sequencing
	// ****************************************************************
	// Overflow in auto mode below the top range aborts and restarts
	assign step_up = conv_active && !cfg_wr && auto_mode && afe_overflow &&
		(cur_range_q < `LRC_RANGE_MAX);
	assign launch = (state_q == ST_IDLE) && start_pend_q && !cfg_wr;
	assign finish = conv_active && !cfg_wr && !step_up && timer_done;
	assign cont_restart = finish && (mode_q != `LRC_MODE_SINGLE);
	// Single shot ends its run and drops back to shutdown
	assign single_done = finish && (mode_q == `LRC_MODE_SINGLE);
	assign timer_start = launch || step_up || cont_restart;
	assign afe_range = cur_range_q;
	assign afe_integrating = timer_busy;

	integration_timer #(
		.CLK_PER_MS(CLK_PER_MS)
	) u_timer (
		.clk_sys(clk_sys),
		.rst(rst),
		.start(timer_start),
		.abort(cfg_wr),
		.long_sel(integration_time_select_q),
		.busy(timer_busy),
		.done(timer_done)
	);

	// ****************************************************************
	// Configuration fields
	// ****************************************************************
	// A write replaces the writable fields and overrides sequencing
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			range_select_q <= RANGE_RST;
			integration_time_select_q <= TIME_RST;
			mode_q <= MODE_RST;
			cfg_low_q <= LOWCFG_RST;
			start_pend_q <= 1'b0;
		end else if (cfg_wr) begin
			range_select_q <= reg_wdata[`LRC_RANGE_HI:`LRC_RANGE_LO];
			integration_time_select_q <= reg_wdata[`LRC_INT_TIME_BIT];
			mode_q <= mode_field(reg_wdata);
			cfg_low_q <= reg_wdata[`LRC_LOWCFG_HI:`LRC_LOWCFG_LO];
			start_pend_q <= (mode_field(reg_wdata) !=
				`LRC_MODE_SHUTDOWN);
		end else begin
			if (launch)
				start_pend_q <= 1'b0;
			if (single_done)
				mode_q <= `LRC_MODE_SHUTDOWN;
		end
	end

	// ****************************************************************
	// Conversion state
	// ****************************************************************
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_q <= ST_IDLE;
		end else if (cfg_wr) begin
			state_q <= ST_IDLE;
		end else begin
			case (state_q)
			ST_IDLE: begin
				if (launch)
					state_q <= ST_CONV;
			end
			ST_CONV: begin
				// Completion of a single shot parks the sequencer
				if (single_done)
					state_q <= ST_IDLE;
			end
			default: begin
				state_q <= ST_IDLE;
			end
			endcase
		end
	end

	// ****************************************************************
	// Range in use and overload memory
	// ****************************************************************
	// Auto ranging restarts low; manual ranging holds the chosen range
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cur_range_q <= `LRC_RANGE_MIN;
			overload_seen_q <= 1'b0;
		end else begin
			case (state_q)
			ST_IDLE: begin
				if (launch) begin
					cur_range_q <= start_range(range_select_q);
					overload_seen_q <= 1'b0;
				end
			end
			ST_CONV: begin
				if (step_up) begin
					cur_range_q <= cur_range_q + 4'h1;
					overload_seen_q <= 1'b0;
				end else if (finish) begin
					overload_seen_q <= 1'b0;
					if (!single_done)
						cur_range_q <= start_range(range_select_q);
				end else if (afe_overflow) begin
					overload_seen_q <= 1'b1;
				end
			end
			default: begin
				cur_range_q <= cur_range_q;
			end
			endcase
		end
	end

	// ****************************************************************
	// Result word
	// ****************************************************************
	// Only a finished, unaborted integration reaches the result
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			result_exp_q <= 4'h0;
			result_man_q <= 12'h000;
			overflow_flag_q <= 1'b0;
		end else if (finish) begin
			// Exponent carries the range in use
			result_exp_q <= cur_range_q;
			result_man_q <= afe_mantissa;
			overflow_flag_q <= overload_seen_q || afe_overflow;
		end
	end

	// ****************************************************************
	// Ready flag
	// ****************************************************************
	// Set by completion wins over clear by a configuration read
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			conversion_ready_flag_q <= 1'b0;
		end else if (finish) begin
			conversion_ready_flag_q <= 1'b1;
		end else if (cfg_rd) begin
			conversion_ready_flag_q <= 1'b0;
		end
	end

	// ****************************************************************
	// Read path
	// ****************************************************************
	// Flag bits come from hardware only and never from the write data
	assign config_word = {range_select_q, integration_time_select_q, mode_q,
		overflow_flag_q, conversion_ready_flag_q, high_flag_in,
		low_flag_in, cfg_low_q};
	assign result_word = {shown_exp(result_exp_q, range_select_q,
		exponent_mask_enable), result_man_q};

	// Writes to the result pointer fall through without effect
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd) begin
			case (reg_addr)
			`LRC_ADDR_RESULT: reg_rdata <= result_word;
			`LRC_ADDR_CONFIG: reg_rdata <= config_word;
			default: reg_rdata <= 16'h0000;
			endcase
		end
	end

endmodule

// File: lrc_props.sv
// Checker of the light sensor register block
`timescale 1ns/1ps
module lrc_props (
	input wire clk_sys,
	input wire rst,
	input wire [7:0] reg_addr,
	input wire reg_wr,
	input wire reg_rd,
	input wire [15:0] reg_wdata,
	input wire [15:0] reg_rdata,
	input wire [11:0] afe_mantissa,
	input wire afe_overflow,
	input wire [3:0] afe_range,
	input wire afe_integrating,
	input wire high_flag_in,
	input wire low_flag_in
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	reg [3:0] rng_q;
	reg msk_q;
	wire cw = reg_wr && reg_addr == 8'h01;
	wire cr = reg_rd && reg_addr == 8'h01;
	wire [1:0] flag_pair = {high_flag_in, low_flag_in};
	// Shadow of the written range and mask
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rng_q <= 4'hc;
			msk_q <= 1'b0;
		end else if (cw) begin
			rng_q <= reg_wdata[15:12];
			msk_q <= reg_wdata[2];
		end
	end
	sequence go_s;
		cw && reg_wdata[10:9] != 2'h0 ##1 !reg_wr;
	endsequence
	chk_cfg_abort: assert property (
		cw |=> !afe_integrating) else $error("run kept after write");
	chk_cfg_start: assert property (
		go_s |=> afe_integrating) else $error("run not started");
	chk_shutdown_idle: assert property (
		cw && reg_wdata[10:9] == 2'h0 |=> !afe_integrating [*2])
		else $error("run in shutdown");
	chk_manual_range: assert property (
		afe_integrating && rng_q < 4'hc |-> afe_range == rng_q)
		else $error("wrong manual range");
	chk_auto_first: assert property (
		$rose(afe_integrating) && rng_q == 4'hc |-> afe_range == 4'h0)
		else $error("auto run not at lowest range");
	chk_auto_step: assert property (
		afe_integrating && rng_q == 4'hc && afe_overflow && !reg_wr
		&& afe_range < 4'hb |=> afe_range == $past(afe_range) + 4'h1)
		else $error("no range step");
	chk_rdata_hold: assert property (
		!reg_rd |=> $stable(reg_rdata)) else $error("read data moved");
	chk_exp_mask: assert property (
		reg_rd && reg_addr == 8'h00 && msk_q && rng_q < 4'hc
		|=> reg_rdata[15:12] == 4'h0) else $error("exponent not masked");
	chk_flag_view: assert property (
		cr |=> reg_rdata[6:5] == $past(flag_pair))
		else $error("flags wrong");
endmodule
bind light_result_config_regs lrc_props u_props (.clk_sys(clk_sys),
	.rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
	.afe_mantissa(afe_mantissa), .afe_overflow(afe_overflow),
	.afe_range(afe_range), .afe_integrating(afe_integrating),
	.high_flag_in(high_flag_in), .low_flag_in(low_flag_in));

// File: afe_model.sv
// Front end model: light count and overflow seen by the block
`timescale 1ns/1ps
module afe_model (
	input wire clk_sys,
	input wire [3:0] afe_range,
	input wire afe_integrating,
	input wire [11:0] count_in,
	input wire [3:0] overload_top,
	output wire [11:0] afe_mantissa,
	output wire afe_overflow
);
	reg [1:0] live_q = 2'b00;
	always @(posedge clk_sys) begin
		live_q <= {live_q[0], afe_integrating};
	end
	// Light beyond full scale of every range below overload_top
	assign afe_overflow = afe_integrating && afe_range < overload_top;
	// Count only valid around integration, scrambled elsewhere
	assign afe_mantissa = (afe_integrating || live_q != 2'b00) ?
		count_in : ~count_in;
endmodule

// File: light_result_config_regs_test.sv
// Self-checking bench of the light sensor register block
`timescale 1ns/1ps
`define CHK(n, e, v) begin compares++; if ((v) !== (e)) begin error_cnt++; \
	$display("wrong value %s exp %h got %h", n, e, v); end end
module light_result_config_regs_test;
	localparam MS = 4;
	typedef struct packed {
		logic [15:0] cfg;
		logic [11:0] man;
		logic [3:0] top;
		logic [15:0] res;
		logic over;
	} row_t;
	// Setup words use range codes up to the auto code only
	// Result words pair an exponent with a mantissa for scaling
	row_t rows [7] = '{'{16'h5200, 12'h123, 4'h0, 16'h5123, 1'b0},
		'{16'hc200, 12'h456, 4'h3, 16'h3456, 1'b0},
		'{16'hc200, 12'hfff, 4'hf, 16'hbfff, 1'b1},
		'{16'h3204, 12'h0aa, 4'h0, 16'h00aa, 1'b0},
		'{16'hc204, 12'h001, 4'h2, 16'h2001, 1'b0},
		'{16'h2200, 12'h0ff, 4'h5, 16'h20ff, 1'b1},
		'{16'hba00, 12'h800, 4'h0, 16'hb800, 1'b0}};
	logic [15:0] cont [2] = '{16'h2600, 16'h1400};
	logic clk_sys = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic high_flag_in = 1'b0, low_flag_in = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [15:0] reg_wdata = 16'h0000, c, r;
	logic [11:0] count_in = 12'h000;
	logic [3:0] overload_top = 4'h0;
	wire [15:0] reg_rdata;
	wire [11:0] afe_mantissa;
	wire [3:0] afe_range;
	wire afe_overflow, afe_integrating;
	int error_cnt = 0, compares = 0, cyc = 0, icnt = 0, t;
	light_result_config_regs #(.CLK_PER_MS(MS)) u_dut (.clk_sys(clk_sys),
		.rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.afe_mantissa(afe_mantissa), .afe_overflow(afe_overflow),
		.afe_range(afe_range), .afe_integrating(afe_integrating),
		.high_flag_in(high_flag_in), .low_flag_in(low_flag_in));
	afe_model u_afe (.clk_sys(clk_sys), .afe_range(afe_range),
		.afe_integrating(afe_integrating), .count_in(count_in),
		.overload_top(overload_top), .afe_mantissa(afe_mantissa),
		.afe_overflow(afe_overflow));
	always #10 clk_sys = ~clk_sys;
	always @(negedge clk_sys) begin
		cyc++;
		icnt += afe_integrating;
		if (cyc == 20000) begin
			error_cnt++;
			test_done;
		end
	end
	task test_done;
		$display("compares %0d errors %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task wr(input [7:0] a, input [15:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task rd(input [7:0] a, output [15:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(posedge clk_sys);
		d = reg_rdata;
	endtask
	// Poll the setup word until a result is ready
	task wait_rdy(output [15:0] d);
		int n;
		n = 0;
		do begin
			rd(8'h01, d);
			n++;
		end while (d[7] !== 1'b1 && n < 2000);
	endtask
	initial begin
		repeat (5) @(posedge clk_sys);
		rst <= 1'b0;
		foreach (rows[i]) begin
			count_in <= rows[i].man;
			overload_top <= rows[i].top;
			t = (rows[i].cfg[11] ? 800 : 100) * MS;
			icnt = 0;
			wr(8'h01, rows[i].cfg);
			wait_rdy(c);
			`CHK("mode", 2'h0, c[10:9])
			`CHK("overflow", rows[i].over, c[8])
			if (rows[i].cfg[15:12] < 4'hc)
				`CHK("span", 1'b1, icnt >= t && icnt <= t + 2)
			rd(8'h00, r);
			`CHK("result", rows[i].res, r)
			$display("row %0d done", i);
		end
		count_in <= 12'h321;
		overload_top <= 4'h0;
		wr(8'h01, 16'h1c00);
		repeat (50) @(posedge clk_sys);
		foreach (cont[k]) begin
			wr(8'h01, cont[k]);
			wait_rdy(c);
			`CHK("run mode", cont[k][10:9], c[10:9])
			rd(8'h00, r);
			`CHK("run result", {cont[k][15:12], 12'h321}, r)
		end
		wr(8'h01, 16'h0000);
		wr(8'h00, 16'hffff);
		repeat (500) @(posedge clk_sys);
		rd(8'h00, r);
		`CHK("result kept", 16'h1321, r)
		$display("abort and shutdown done");
		high_flag_in <= 1'b1;
		low_flag_in <= 1'b1;
		rst <= 1'b1;
		repeat (5) @(posedge clk_sys);
		rst <= 1'b0;
		rd(8'h01, c);
		`CHK("setup reset", 16'hc870, c)
		rd(8'h00, r);
		`CHK("result reset", 16'h0000, r)
		wr(8'h01, 16'h01ff);
		rd(8'h01, c);
		`CHK("setup bits", 16'h007f, c)
		$display("reset and access done");
		test_done;
	end
endmodule
